// ===== hw/psp_cfg.svh
/*
 * Register offsets, field positions and reset values of the parallel slave port.
 * Assumes byte addresses on an 8-bit APB address, one aligned 32-bit word per register.
 */
`ifndef SLAVE_PORT_CFG_SVH
`define SLAVE_PORT_CFG_SVH

`define OFF_DATA_PINS   8'h00
`define OFF_DATA_LATCH  8'h04
`define OFF_DATA_DIR    8'h08
`define OFF_CTRL_PINS   8'h0c
`define OFF_CTRL_LATCH  8'h10
`define OFF_CTRL_STAT   8'h14
`define OFF_CONV_CFG    8'h18
`define OFF_IRQ_FLAG    8'h1c

`define BIT_IN_PEND     7
`define BIT_OUT_PEND    6
`define BIT_OVERRUN     5
`define BIT_PORT_SEL    4
`define BIT_CS_DIR      2
`define BIT_WR_DIR      1
`define BIT_RD_DIR      0
`define BIT_IRQ_FLAG    0

`define RST_CTRL_DIR    3'h7
`define RST_DATA_DIR    8'hff
`define RST_DATA_LATCH  8'h00
`define RST_CTRL_LATCH  3'h0
`define RST_CONV_CFG    4'h0
`define CONV_DIGITAL_LO 4'ha
`define FIFO_WORDS      16

`endif

// ===== hw/psp_pkg.sv
/*
 * Types shared by the parallel slave port modules.
 * Assumes psp_cfg.svh is compiled alongside for the numeric constants.
 */
package slave_port_pkg;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
    } strobe_s;

    typedef struct packed {
        logic [7:0]  data_latch;
        logic [7:0]  data_dir;
        logic [2:0]  ctrl_latch;
        logic [2:0]  ctrl_dir;
        logic        port_sel;
        logic        overrun;
        logic        out_pend;
        logic        irq_flag;
        logic [3:0]  conv_cfg;
        logic        wr_on;
        logic        rd_on;
        logic [7:0]  wr_sample;
        logic        push_pend;
        logic [7:0]  push_byte;
        logic [31:0] rdata;
    } core_state_s;

endpackage

// ===== hw/strobe_sync.sv
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes the levels change slowly compared with the clock; one bit per line.
 */
`timescale 1ns/10ps
module strobe_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    input  wire logic [W-1:0] init,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_s;

    sync_state_s s_r;
    sync_state_s s_nxt;

    // Stage one feeds only stage two
    always_comb begin
        s_nxt        = s_r;
        s_nxt.meta   = d;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '1;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.stable;

    // Unused reset level hook; reset loads all ones, not init
    logic unused_init;
    assign unused_init = ^init;
endmodule

// ===== hw/byte_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; out_data is the registered head entry.
 */
`timescale 1ns/10ps
module byte_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } fifo_state_s;

    fifo_state_s s_r;
    fifo_state_s s_nxt;
    logic        push;
    logic        pop;

    assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_r.cnt != '0);
    assign out_data  = s_r.mem[s_r.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end
endmodule

// ===== hw/parallel_slave_port.sv
/*
 * Parallel slave port with its general-purpose data and control pins, APB registers.
 * Assumes pin inputs synchronous to CORE_CLK except the three strobes, which are resynchronised;
 * pad logic outside resolves each pin from OUT and OE_N.
 */
// Our own choices: the placing of the registers and register access over APB.
// What this block and its software do
// RULE_01: Input-pending bit is one while a received word waits for the CPU.
// RULE_02: Output-pending bit is one until the external processor reads the written word.
// RULE_03: Overrun sets on a write while a word is unread; only writing zero clears.
// RULE_04: Port-select bit chooses slave operation when one; resets to zero.
// RULE_05: Three control direction bits, one means input; reset to one.
// RULE_06: Slave operation is blocked while the PWM unit runs dual or quad output.
// RULE_07: In slave mode the eight data pins form the external processor's byte bus.
// RULE_08: Control pins act as read strobe, write strobe and chip select, active low.
// RULE_09: Software sets control pins to input and converter config to 1010..1111.
// RULE_10: A write runs from chip select and write both low until either goes high.
// RULE_11: At write end capture the byte, set the port flag and input-pending.
// RULE_12: Chip select and read low drive the latch out and clear output-pending.
// RULE_13: A CPU data write during a read drives at once, output-pending stays clear.
// RULE_14: When the read ends, release the data pins and set the port flag.
// RULE_15: Software waits for the port flag, then polls the pending bits.
// RULE_16: Analog control pins read zero digitally, yet still drive when set to output.
// RULE_17: After reset the control pins default to analog channels.
// RULE_18: Slave read data takes priority over ordinary port output on data pins.
// RULE_19: Chip select, read and write strobes are synchronised before edge detection.
`timescale 1ns/10ps
`include "psp_cfg.svh"
module parallel_slave_port
    import slave_port_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_WORDS
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        CLK_EN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic             PREADY,
    output logic      [31:0] PRDATA,
    output logic             PSLVERR,
    input  wire logic [7:0]  DATA_PIN_IN,
    output logic      [7:0]  DATA_PIN_OUT,
    output logic      [7:0]  DATA_PIN_OE_N,
    input  wire logic [2:0]  CTRL_PIN_IN,
    output logic      [2:0]  CTRL_PIN_OUT,
    output logic      [2:0]  CTRL_PIN_OE_N,
    input  wire logic        PWM_MULTI_OUT,
    output logic      [2:0]  ANALOG_SEL,
    output logic             SLAVE_ACTIVE,
    output logic             IRQ_FLAG
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Converter codes below the lowest all-digital code leave the three pins analog
    function automatic logic [2:0] analog_pins(input logic [3:0] cfg);
        analog_pins = (cfg < `CONV_DIGITAL_LO) ? 3'h7 : 3'h0;
    endfunction

    function automatic logic addr_hit(input logic [7:0] a);
        unique case (a)
            `OFF_DATA_PINS, `OFF_DATA_LATCH, `OFF_DATA_DIR, `OFF_CTRL_PINS,
            `OFF_CTRL_LATCH, `OFF_CTRL_STAT, `OFF_CONV_CFG, `OFF_IRQ_FLAG:
                addr_hit = 1'b1;
            default:
                addr_hit = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State and submodules

    core_state_s s_r;
    core_state_s s_nxt;

    strobe_s     strobe_raw;
    strobe_s     strobe_sync_q;
    logic        eff_mode;
    logic        wr_act;
    logic        rd_act;
    logic        in_pend;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [7:0]  fifo_out_data;
    logic        fifo_pop;
    logic        apb_wr;
    logic        apb_rd;
    logic        apb_setup;
    logic [2:0]  ctrl_digital;

    // Pin 2 is chip select, pin 1 write strobe, pin 0 read strobe
    assign strobe_raw = '{cs_n: CTRL_PIN_IN[2], wr_n: CTRL_PIN_IN[1], rd_n: CTRL_PIN_IN[0]}; // RULE_08

    strobe_sync #(
        .W (3)
    ) u_strobe_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .ce    (CLK_EN),
        .d     (strobe_raw),
        .init  (3'h7),
        .q     (strobe_sync_q)
    ); // RULE_19

    // Received bytes queue here; a full queue stalls the capture holding register
    byte_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .ce        (CLK_EN),
        .in_valid  (s_r.push_pend),
        .in_ready  (fifo_in_ready),
        .in_data   (s_r.push_byte),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transfer detection

    assign eff_mode = s_r.port_sel & ~PWM_MULTI_OUT; // RULE_04 RULE_06
    assign wr_act   = eff_mode & ~strobe_sync_q.cs_n & ~strobe_sync_q.wr_n; // RULE_10
    assign rd_act   = eff_mode & ~strobe_sync_q.cs_n & ~strobe_sync_q.rd_n; // RULE_12
    assign in_pend  = fifo_out_valid | s_r.push_pend; // RULE_01

    assign apb_setup = PSEL & ~PENABLE;
    assign apb_wr    = PSEL & PENABLE & PWRITE;
    assign apb_rd    = PSEL & PENABLE & ~PWRITE;
    // Reading the pin register in slave mode consumes the oldest received byte
    assign fifo_pop  = apb_rd & (PADDR == `OFF_DATA_PINS) & eff_mode;

    // Analog pins read back as zero on the digital path
    assign ctrl_digital = CTRL_PIN_IN & ~analog_pins(s_r.conv_cfg); // RULE_16

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt = s_r;

        // Software writes first, so that hardware events below win over clears
        if (apb_wr) begin
            unique case (PADDR)
                `OFF_DATA_PINS, `OFF_DATA_LATCH: begin
                    s_nxt.data_latch = PWDATA[7:0];
                    if (eff_mode && !rd_act) begin
                        s_nxt.out_pend = 1'b1; // RULE_02
                    end
                end
                `OFF_DATA_DIR: begin
                    s_nxt.data_dir = PWDATA[7:0];
                end
                `OFF_CTRL_PINS, `OFF_CTRL_LATCH: begin
                    s_nxt.ctrl_latch = PWDATA[2:0];
                end
                `OFF_CTRL_STAT: begin
                    s_nxt.port_sel = PWDATA[`BIT_PORT_SEL]; // RULE_04
                    s_nxt.ctrl_dir = PWDATA[`BIT_CS_DIR:`BIT_RD_DIR]; // RULE_05
                    if (!PWDATA[`BIT_OVERRUN]) begin
                        s_nxt.overrun = 1'b0; // RULE_03
                    end
                end
                `OFF_CONV_CFG: begin
                    s_nxt.conv_cfg = PWDATA[3:0];
                end
                `OFF_IRQ_FLAG: begin
                    if (!PWDATA[`BIT_IRQ_FLAG]) begin
                        s_nxt.irq_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data is registered in the setup cycle and presented in the access cycle
        if (apb_setup) begin
            s_nxt.rdata = '0;
            unique case (PADDR)
                `OFF_DATA_PINS:
                    s_nxt.rdata[7:0] = eff_mode ? fifo_out_data : DATA_PIN_IN;
                `OFF_DATA_LATCH:
                    s_nxt.rdata[7:0] = s_r.data_latch;
                `OFF_DATA_DIR:
                    s_nxt.rdata[7:0] = s_r.data_dir;
                `OFF_CTRL_PINS:
                    s_nxt.rdata[2:0] = ctrl_digital; // RULE_16
                `OFF_CTRL_LATCH:
                    s_nxt.rdata[2:0] = s_r.ctrl_latch;
                `OFF_CTRL_STAT: begin
                    s_nxt.rdata[`BIT_IN_PEND]             = in_pend; // RULE_01
                    s_nxt.rdata[`BIT_OUT_PEND]            = s_r.out_pend; // RULE_02
                    s_nxt.rdata[`BIT_OVERRUN]             = s_r.overrun;
                    s_nxt.rdata[`BIT_PORT_SEL]            = s_r.port_sel;
                    s_nxt.rdata[`BIT_CS_DIR:`BIT_RD_DIR]  = s_r.ctrl_dir;
                end
                `OFF_CONV_CFG:
                    s_nxt.rdata[3:0] = s_r.conv_cfg;
                `OFF_IRQ_FLAG:
                    s_nxt.rdata[`BIT_IRQ_FLAG] = s_r.irq_flag;
                default: begin
                end
            endcase
        end

        // Capture stage drains into the queue when it has room
        if (s_r.push_pend && fifo_in_ready) begin
            s_nxt.push_pend = 1'b0;
        end

        // Sample the bus every cycle of the write so the last seen byte is kept
        if (wr_act) begin
            s_nxt.wr_sample = DATA_PIN_IN; // RULE_07
        end
        if (s_r.wr_on && !wr_act) begin
            s_nxt.push_pend = 1'b1; // RULE_11
            s_nxt.push_byte = s_r.wr_sample; // RULE_11
            s_nxt.irq_flag  = 1'b1; // RULE_11
            if (in_pend) begin
                s_nxt.overrun = 1'b1; // RULE_03
            end
        end

        if (rd_act) begin
            s_nxt.out_pend = 1'b0; // RULE_12 RULE_13
        end
        if (s_r.rd_on && !rd_act) begin
            s_nxt.irq_flag = 1'b1; // RULE_14
        end

        s_nxt.wr_on = wr_act;
        s_nxt.rd_on = rd_act;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r            <= '0;
            s_r.data_latch <= `RST_DATA_LATCH;
            s_r.data_dir   <= `RST_DATA_DIR;
            s_r.ctrl_latch <= `RST_CTRL_LATCH;
            s_r.ctrl_dir   <= `RST_CTRL_DIR; // RULE_05
            s_r.conv_cfg   <= `RST_CONV_CFG; // RULE_17
        end else if (CLK_EN) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answers and pins

    // Zero-wait slave: every access phase completes in its first cycle
    assign PREADY  = PSEL & PENABLE;
    assign PRDATA  = s_r.rdata;
    assign PSLVERR = PSEL & PENABLE & ~addr_hit(PADDR);

    // The latch feeds the pins directly, so a CPU write shows during a read
    assign DATA_PIN_OUT = s_r.data_latch; // RULE_13

    always_comb begin
        if (eff_mode) begin
            DATA_PIN_OE_N = rd_act ? 8'h00 : 8'hff; // RULE_12 RULE_14 RULE_18
        end else begin
            DATA_PIN_OE_N = s_r.data_dir;
        end
    end

    // Direction bits still govern the drivers on analog pins
    assign CTRL_PIN_OUT  = s_r.ctrl_latch; // RULE_16
    assign CTRL_PIN_OE_N = s_r.ctrl_dir; // RULE_05 RULE_16
    assign ANALOG_SEL    = analog_pins(s_r.conv_cfg); // RULE_17
    assign SLAVE_ACTIVE  = eff_mode;
    assign IRQ_FLAG      = s_r.irq_flag;
endmodule

// ===== dv/psp_props.sv
/*
 * Checker on the parallel slave port's top-level pins.
 * Assumes the external strobes stay at each level for at least three clocks.
 */
`timescale 1ns/10ps
module slave_port_props (
    input wire logic       CORE_CLK,
    input wire logic       RST_N,
    input wire logic       PSEL,
    input wire logic       PENABLE,
    input wire logic [7:0] PADDR,
    input wire logic       PSLVERR,
    input wire logic [2:0] CTRL_PIN_IN,
    input wire logic [2:0] CTRL_PIN_OE_N,
    input wire logic [7:0] DATA_PIN_OE_N,
    input wire logic       PWM_MULTI_OUT,
    input wire logic [2:0] ANALOG_SEL,
    input wire logic       SLAVE_ACTIVE,
    input wire logic       IRQ_FLAG
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    ////////////////////////////////////////////////////////////////////////
    sequence s_wr_low;
        SLAVE_ACTIVE && CTRL_PIN_IN[2:1] == 2'h0;
    endsequence
    sequence s_wr_end;
        (CTRL_PIN_IN[2] || CTRL_PIN_IN[1]) [*3];
    endsequence
    // Three low samples make sure the synchroniser saw the window open
    property p_wr_flag;
        s_wr_low [*3] ##1 s_wr_end |-> ##[1:2] IRQ_FLAG;
    endproperty
    property p_rd_drive;
        (SLAVE_ACTIVE && !CTRL_PIN_IN[2] && !CTRL_PIN_IN[0]) [*5] |-> DATA_PIN_OE_N == 8'h00;
    endproperty
    property p_rd_release;
        (SLAVE_ACTIVE && CTRL_PIN_IN[0]) [*5] |-> DATA_PIN_OE_N == 8'hff;
    endproperty
    // Mode entry also lifts the enables, so only a steady slave mode counts
    property p_rd_flag;
        SLAVE_ACTIVE && $past(SLAVE_ACTIVE) && $rose(DATA_PIN_OE_N[0]) |-> ##[0:2] IRQ_FLAG;
    endproperty
    property p_pwm_block;
        PWM_MULTI_OUT |-> !SLAVE_ACTIVE;
    endproperty
    property p_rst_dirs;
        $rose(RST_N) |-> CTRL_PIN_OE_N == 3'h7;
    endproperty
    property p_rst_analog;
        $rose(RST_N) |-> ANALOG_SEL == 3'h7;
    endproperty
    property p_rst_mode;
        $rose(RST_N) |-> !SLAVE_ACTIVE && !IRQ_FLAG;
    endproperty
    property p_unmapped;
        PSEL && PENABLE && PADDR > 8'h1c |-> PSLVERR;
    endproperty

    ////////////////////////////////////////////////////////////////////////
    a_wr_flag: assert property (p_wr_flag) else $error("no flag after write");
    a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
    a_rd_release: assert property (p_rd_release) else $error("pins kept");
    a_rd_flag: assert property (p_rd_flag) else $error("no flag after read");
    a_pwm_block: assert property (p_pwm_block) else $error("slave under pwm");
    a_rst_dirs: assert property (p_rst_dirs) else $error("dirs not input");
    a_rst_analog: assert property (p_rst_analog) else $error("not analog");
    a_rst_mode: assert property (p_rst_mode) else $error("mode not gpio");
    a_unmapped: assert property (p_unmapped) else $error("unmapped no error");
endmodule

// ===== dv/ext_cpu_model.sv
/*
 * External processor on the slave port's byte bus and strobes.
 * Assumes the bench resolves the strobe pins; strobe_n is {cs, wr, rd}, active low.
 */
`timescale 1ns/10ps
module ext_cpu_model (
    input wire logic       clk,
    input wire logic [7:0] dev_out,
    input wire logic [7:0] dev_oe_n,
    output logic     [2:0] strobe_n,
    output logic     [7:0] bus
);
    logic [7:0] drv;

    // No pull on the bus: when released we show the inverse of the last byte
    assign bus = (dev_oe_n & drv) | (~dev_oe_n & dev_out);

    initial begin
        strobe_n = 3'h7;
        drv      = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] b, input int n);
        @(posedge clk);
        drv      <= b;
        strobe_n <= 3'h1;
        repeat (n) @(posedge clk);
        strobe_n <= 3'h7;
        // Data held past the strobe: the device samples through its synchroniser
        repeat (3) @(posedge clk);
        drv <= ~b;
        repeat (3) @(posedge clk);
    endtask

    task automatic rd(output logic [7:0] b, input int n);
        @(posedge clk);
        strobe_n <= 3'h2;
        repeat (n) @(posedge clk);
        // Bus taken at the same edge that ends the strobe
        @(posedge clk);
        b = bus;
        strobe_n <= 3'h7;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ===== dv/test_parallel_slave_port.sv
/*
 * Self-checking bench for the parallel slave port: APB master, scenarios, verdict.
 * Assumes ext_cpu_model on the pins and the property checker bound to the top module.
 */
`timescale 1ns/10ps
module test_parallel_slave_port;
    logic        clk, rst_n, psel, penable, pwrite, pwm, rerr, ce;
    logic [7:0]  paddr, din, dout, doe_n;
    logic [31:0] pwdata, prdata, rdat;
    logic        pready, pslverr, sact, irq;
    logic [2:0]  cin, cout, coe_n, asel, strobe_n;
    int          err_count, n_tests;

    parallel_slave_port i_parallel_slave_port (
        .CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(ce), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
        .PRDATA(prdata), .PSLVERR(pslverr), .DATA_PIN_IN(din), .DATA_PIN_OUT(dout),
        .DATA_PIN_OE_N(doe_n), .CTRL_PIN_IN(cin), .CTRL_PIN_OUT(cout),
        .CTRL_PIN_OE_N(coe_n), .PWM_MULTI_OUT(pwm), .ANALOG_SEL(asel),
        .SLAVE_ACTIVE(sact), .IRQ_FLAG(irq));
    ext_cpu_model i_ext_cpu_model (
        .clk(clk), .dev_out(dout), .dev_oe_n(doe_n), .strobe_n(strobe_n), .bus(din));

    assign cin = (coe_n & strobe_n) | (~coe_n & cout);

    always #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        // Wait states are left to the design; only the watchdog ends a hung access
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk($sformatf("reg %h", a), rdat, e);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rreg(8'h14, 32'h07);
        rreg(8'h18, 32'h00);
        rreg(8'h0c, 32'h00);
        chk("asel", asel, 3'h7);
        chk("sact", sact, 1'h0);
        apb(1'h0, 8'h20, 32'h0);
        chk("slverr", rerr, 1'h1);
        chk("unmapped", rdat, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_gpio;
        wreg(8'h14, 32'h05);
        wreg(8'h10, 32'h07);
        chk("coe", coe_n, 3'h5);
        chk("cout", cout, 3'h7);
        // A frozen clock enable must swallow a register write
        ce <= 1'h0;
        wreg(8'h10, 32'h00);
        chk("frozen", cout, 3'h7);
        ce <= 1'h1;
        rreg(8'h0c, 32'h00);
        wreg(8'h08, 32'h00);
        wreg(8'h00, 32'ha5);
        chk("doe", doe_n, 8'h00);
        chk("dout", dout, 8'ha5);
        rreg(8'h00, 32'ha5);
        wreg(8'h08, 32'hff);
        $display("test gpio done");
    endtask

    task automatic t_setup;
        wreg(8'h18, 32'h0a);
        pwm <= 1'h1;
        wreg(8'h14, 32'h17);
        chk("sact", sact, 1'h0);
        i_ext_cpu_model.wr(8'h11, 6);
        chk("irq", irq, 1'h0);
        rreg(8'h14, 32'h17);
        pwm <= 1'h0;
        @(posedge clk);
        chk("sact", sact, 1'h1);
        chk("asel", asel, 3'h0);
        rreg(8'h0c, 32'h07);
        $display("test setup done");
    endtask

    task automatic t_write;
        int k;
        i_ext_cpu_model.wr(8'h3c, 4);
        for (k = 0; k < 50 && irq !== 1'h1; k++)
            @(posedge clk);
        rreg(8'h1c, 32'h01);
        rreg(8'h14, 32'h97);
        i_ext_cpu_model.wr(8'h5a, 8);
        rreg(8'h14, 32'hb7);
        rreg(8'h00, 32'h3c);
        rreg(8'h00, 32'h5a);
        rreg(8'h14, 32'h37);
        wreg(8'h14, 32'h37);
        rreg(8'h14, 32'h37);
        wreg(8'h14, 32'h17);
        rreg(8'h14, 32'h17);
        wreg(8'h1c, 32'h00);
        chk("irq", irq, 1'h0);
        $display("test write done");
    endtask

    task automatic t_read;
        logic [7:0] b;
        wreg(8'h08, 32'h00);
        chk("doe", doe_n, 8'hff);
        wreg(8'h00, 32'hc3);
        rreg(8'h14, 32'h57);
        i_ext_cpu_model.rd(b, 6);
        chk("bus", b, 8'hc3);
        rreg(8'h14, 32'h17);
        chk("irq", irq, 1'h1);
        chk("doe", doe_n, 8'hff);
        wreg(8'h1c, 32'h00);
        $display("test read done");
    endtask

    task automatic t_rd_update;
        logic [7:0] b;
        fork
            i_ext_cpu_model.rd(b, 16);
            begin
                repeat (8) @(posedge clk);
                wreg(8'h00, 32'h69);
            end
        join
        chk("bus", b, 8'h69);
        rreg(8'h14, 32'h17);
        wreg(8'h1c, 32'h00);
        $display("test read update done");
    endtask

    // Sixteen in the buffer plus one held in capture; the eighteenth replaces the held one
    task automatic t_fifo;
        for (int i = 0; i < 18; i++)
            i_ext_cpu_model.wr(8'(i + 8'h40), 4);
        rreg(8'h14, 32'hb7);
        for (int i = 0; i < 16; i++)
            rreg(8'h00, 32'(i + 8'h40));
        rreg(8'h00, 32'h51);
        rreg(8'h14, 32'h37);
        $display("test fifo done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        rst_n = 1'h0;
        {psel, penable, pwrite, pwm} = 4'h0;
        ce = 1'h1;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        t_reset;
        t_gpio;
        t_setup;
        t_write;
        t_read;
        t_rd_update;
        t_fifo;
        print_verdict;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict;
    end
endmodule

bind parallel_slave_port slave_port_props i_slave_port_props (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
    .PSLVERR(PSLVERR), .CTRL_PIN_IN(CTRL_PIN_IN), .CTRL_PIN_OE_N(CTRL_PIN_OE_N),
    .DATA_PIN_OE_N(DATA_PIN_OE_N), .PWM_MULTI_OUT(PWM_MULTI_OUT),
    .ANALOG_SEL(ANALOG_SEL), .SLAVE_ACTIVE(SLAVE_ACTIVE), .IRQ_FLAG(IRQ_FLAG));
